// ---- rstc_consts.vh ----
// constants for the read snoop termination controller
`ifndef RSTC_CONSTS_VH
`define RSTC_CONSTS_VH

// register byte offsets
`define RSTC_OFS_CFG 4'h0
`define RSTC_OFS_STAT 4'h4
`define RSTC_OFS_RDCNT 4'h8

// config register fields
`define RSTC_CFG_LAT_LSB 0
`define RSTC_CFG_LAT_W 4
`define RSTC_CFG_BL_LSB 8
`define RSTC_CFG_BL_W 5
`define RSTC_CFG_SNOOP_BIT 16

// config reset values
`define RSTC_LAT_RST 4'h7
`define RSTC_BL_RST 5'h04
`define RSTC_SNOOP_RST 1'b1

// status register bits
`define RSTC_ST_DUAL 0
`define RSTC_ST_CAPT 1
`define RSTC_ST_DQON 2
`define RSTC_ST_HALFZQ 3
`define RSTC_ST_SEL_LSB 4
`define RSTC_ST_PEND 6

// data group termination select, held in the extended mode register
`define RSTC_EMR_SEL_LSB 2
`define RSTC_SEL_OFF 2'h0
`define RSTC_SEL_DUAL 2'h1
`define RSTC_SEL_SINGLE 2'h2
`define RSTC_SEL_RST 2'h1

// off window length is half the burst plus this
`define RSTC_OFF_EXTRA 5'h02

`endif

// ---- rstc_pin_sync.v ----
// two flip-flop synchroniser, one per bit
`timescale 1ns/1ps
module rstc_pin_sync #(
  parameter W = 1
) (
  input wire clk,
  input wire rst_b,
  input wire [W-1:0] pin_in,
  output wire [W-1:0] pin_out
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta_q;
      reg sync_q;
      always @(posedge clk) begin
        if (!rst_b) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else begin
          meta_q <= pin_in[i];
          sync_q <= meta_q;
        end
      end
      assign pin_out[i] = sync_q;
    end
  endgenerate
endmodule // rstc_pin_sync

// ---- rstc_off_timer.v ----
// delay line and off-window counter, stepped once per link clock rising edge
`timescale 1ns/1ps
module rstc_off_timer #(
  parameter LAT_W = 4,
  parameter DUR_W = 5
) (
  input wire clk,
  input wire rst_b,
  input wire tick,
  input wire read_hit,
  input wire [LAT_W-1:0] lat,
  input wire [DUR_W-1:0] dur,
  output wire pending,
  output wire term_off
);
  localparam DEPTH = 1 << LAT_W;
  reg [DEPTH-1:0] hist_q;
  reg [DUR_W-1:0] cnt_q;
  reg [LAT_W-1:0] lat_m1;
  reg start;

  // start tap sits latency minus one link clocks after the read
  always @* begin
    lat_m1 = lat - {{(LAT_W-1){1'b0}}, 1'b1};
    if (lat_m1 == {LAT_W{1'b0}} || lat == {LAT_W{1'b0}}) begin
      start = read_hit;
    end else begin
      start = hist_q[lat_m1 - {{(LAT_W-1){1'b0}}, 1'b1}];
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      hist_q <= {DEPTH{1'b0}};
      cnt_q <= {DUR_W{1'b0}};
    end else if (tick) begin
      hist_q <= {hist_q[DEPTH-2:0], read_hit};
      // a later read reloads the count, stretching the window over both
      if (start) begin
        cnt_q <= dur;
      end else if (cnt_q != {DUR_W{1'b0}}) begin
        cnt_q <= cnt_q - {{(DUR_W-1){1'b0}}, 1'b1};
      end
    end
  end

  assign pending = |hist_q;
  assign term_off = (cnt_q != {DUR_W{1'b0}});
endmodule // rstc_off_timer

// ---- rstc_snoop_term.v ----
// read snoop data termination controller with avalon register slave
`timescale 1ns/1ps
`include "rstc_consts.vh"

// Contract
// - Any read on the command bus, chip select ignored, switches data termination off.
// - Termination goes off read latency minus one link clocks after the read.
// - Termination stays off half the burst length plus two clocks, then on.
// - Read snooping acts only when data termination is set to dual-load.
// - Reads aimed at either rank switch this device's data terminators off.
// - Command, address and other pin termination stays on always.
// - First reset pin rise samples clock enable; low means single rank, half reference.
// - Clock enable high at that rise selects dual rank configuration.
// - Extended mode register field selects data, strobe and mask termination.
module rstc_snoop_term #(
  parameter LAT_W = `RSTC_CFG_LAT_W,
  parameter BL_W = `RSTC_CFG_BL_W
) (
  input wire clk,
  input wire rst_b,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire link_ck,
  input wire cs_n,
  input wire ras_n,
  input wire cas_n,
  input wire we_n,
  input wire bank_addr_bit0,
  input wire bank_addr_bit1,
  input wire [11:0] addr,
  input wire cke,
  input wire dram_reset_pin,
  output wire dq_group_term_en,
  output wire [1:0] dq_group_term_sel,
  output wire cmd_addr_term_en,
  output wire addr_term_half_ref,
  output wire dual_rank
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  localparam NPIN = 21;
  wire [NPIN-1:0] pin_s;

  rstc_pin_sync #(
    .W(NPIN)
  ) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pin_in({link_ck, cs_n, ras_n, cas_n, we_n, bank_addr_bit0,
             bank_addr_bit1, addr, cke, dram_reset_pin}),
    .pin_out(pin_s)
  );

  wire ck_s = pin_s[20];
  wire cs_n_s = pin_s[19];
  wire ras_n_s = pin_s[18];
  wire cas_n_s = pin_s[17];
  wire we_n_s = pin_s[16];
  wire ba0_s = pin_s[15];
  wire ba1_s = pin_s[14];
  wire [11:0] addr_s = pin_s[13:2];
  wire cke_s = pin_s[1];
  wire rst_pin_s = pin_s[0];

  // ****************************************
  // link clock edge and reset pin edge
  // ****************************************
  reg ck_prev_q;
  reg rst_pin_prev_q;
  reg [1:0] settle_q;
  reg [1:0] settle_d;
  wire settled = (settle_q == 2'h3);
  wire ck_rise = settled & ck_s & ~ck_prev_q;
  // synchroniser flops leave reset low, so a pin idling high would look
  // like a rise until its level has walked through them
  wire rst_pin_rise = settled & rst_pin_s & ~rst_pin_prev_q;

  always @* begin
    settle_d = settle_q;
    if (!settled) begin
      settle_d = settle_q + 2'h1;
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      ck_prev_q <= 1'b0;
      rst_pin_prev_q <= 1'b1;
      settle_q <= 2'h0;
    end else begin
      ck_prev_q <= ck_s;
      rst_pin_prev_q <= rst_pin_s;
      settle_q <= settle_d;
    end
  end

  // ****************************************
  // rank configuration strap
  // ****************************************
  reg capt_q;
  reg capt_d;
  reg dual_q;
  reg dual_d;

  // settle count masks the synchroniser walk, so a pin held high at release is not a rise
  // capture once per rst_b; later reset pin pulses leave the strap alone
  always @* begin
    capt_d = capt_q;
    dual_d = dual_q;
    if (rst_pin_rise && !capt_q) begin
      capt_d = 1'b1;
      dual_d = cke_s;
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      capt_q <= 1'b0;
      dual_q <= 1'b0;
    end else begin
      capt_q <= capt_d;
      dual_q <= dual_d;
    end
  end

  assign dual_rank = dual_q;
  assign addr_term_half_ref = capt_q & ~dual_q;
  assign cmd_addr_term_en = 1'b1;

  // ****************************************
  // command decode
  // ****************************************
  // read decode leaves chip select out, so reads to either rank count
  wire cmd_read = ck_rise & ras_n_s & ~cas_n_s & we_n_s;
  wire cmd_lmr = ck_rise & ~cs_n_s & ~ras_n_s & ~cas_n_s & ~we_n_s;
  wire cmd_emr = cmd_lmr & ba0_s & ~ba1_s;

  reg [1:0] sel_q;
  reg [1:0] sel_d;

  always @* begin
    sel_d = sel_q;
    if (cmd_emr) begin
      sel_d = addr_s[`RSTC_EMR_SEL_LSB +: 2];
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      sel_q <= `RSTC_SEL_RST;
    end else begin
      sel_q <= sel_d;
    end
  end

  assign dq_group_term_sel = sel_q;

  // ****************************************
  // configuration registers
  // ****************************************
  reg [LAT_W-1:0] lat_q;
  reg [LAT_W-1:0] lat_d;
  reg [BL_W-1:0] bl_q;
  reg [BL_W-1:0] bl_d;
  reg snoop_en_q;
  reg snoop_en_d;
  reg [15:0] rdcnt_q;
  reg [15:0] rdcnt_d;
  reg ack_q;

  wire req = avs_read | avs_write;
  wire wr_cfg = avs_write & ~ack_q & (avs_address == `RSTC_OFS_CFG);

  always @* begin
    lat_d = lat_q;
    bl_d = bl_q;
    snoop_en_d = snoop_en_q;
    if (wr_cfg) begin
      lat_d = avs_writedata[`RSTC_CFG_LAT_LSB +: LAT_W];
      bl_d = avs_writedata[`RSTC_CFG_BL_LSB +: BL_W];
      snoop_en_d = avs_writedata[`RSTC_CFG_SNOOP_BIT];
    end
  end

  // a new latency or burst also applies to reads already in the delay line whose window has not yet started
  always @(posedge clk) begin
    if (!rst_b) begin
      lat_q <= `RSTC_LAT_RST;
      bl_q <= `RSTC_BL_RST;
      snoop_en_q <= `RSTC_SNOOP_RST;
    end else begin
      lat_q <= lat_d;
      bl_q <= bl_d;
      snoop_en_q <= snoop_en_d;
    end
  end

  // ****************************************
  // termination off window
  // ****************************************
  wire snoop_on = snoop_en_q & (sel_q == `RSTC_SEL_DUAL);
  wire read_hit = cmd_read & snoop_on;
  wire [BL_W-1:0] dur = (bl_q >> 1) + `RSTC_OFF_EXTRA;
  wire pending;
  wire term_off;

  rstc_off_timer #(
    .LAT_W(LAT_W),
    .DUR_W(BL_W)
  ) u_timer (
    .clk(clk),
    .rst_b(rst_b),
    .tick(ck_rise),
    .read_hit(read_hit),
    .lat(lat_q),
    .dur(dur),
    .pending(pending),
    .term_off(term_off)
  );

  // dual-load off only during the window; select off leaves pins open
  assign dq_group_term_en = (sel_q != `RSTC_SEL_OFF) & ~term_off;

  // ****************************************
  // read counter
  // ****************************************
  // wraps silently; software compares differences
  always @* begin
    rdcnt_d = rdcnt_q;
    if (read_hit) begin
      rdcnt_d = rdcnt_q + 16'h0001;
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      rdcnt_q <= 16'h0000;
    end else begin
      rdcnt_q <= rdcnt_d;
    end
  end

  // ****************************************
  // avalon slave: one wait state per access
  // ****************************************
  reg [31:0] rd_d;

  always @* begin
    rd_d = 32'h00000000;
    case (avs_address)
      `RSTC_OFS_CFG: begin
        rd_d[`RSTC_CFG_LAT_LSB +: LAT_W] = lat_q;
        rd_d[`RSTC_CFG_BL_LSB +: BL_W] = bl_q;
        rd_d[`RSTC_CFG_SNOOP_BIT] = snoop_en_q;
      end
      `RSTC_OFS_STAT: begin
        rd_d[`RSTC_ST_DUAL] = dual_q;
        rd_d[`RSTC_ST_CAPT] = capt_q;
        rd_d[`RSTC_ST_DQON] = dq_group_term_en;
        rd_d[`RSTC_ST_HALFZQ] = addr_term_half_ref;
        rd_d[`RSTC_ST_SEL_LSB +: 2] = sel_q;
        rd_d[`RSTC_ST_PEND] = pending;
      end
      `RSTC_OFS_RDCNT: begin
        rd_d[15:0] = rdcnt_q;
      end
      default: begin
        rd_d = 32'h00000000;
      end
    endcase
  end

  reg ack_d;
  reg [31:0] readdata_d;

  // one wait state keeps the read mux off the bus path at full clock rate
  always @* begin
    ack_d = req & ~ack_q;
    readdata_d = avs_readdata;
    if (avs_read && !ack_q) begin
      readdata_d = rd_d;
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      ack_q <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else begin
      ack_q <= ack_d;
      avs_readdata <= readdata_d;
    end
  end

  assign avs_waitrequest = req & ~ack_q;
endmodule // rstc_snoop_term

// ---- rstc_snoop_term_properties.sv ----
// port assertions for the read snoop termination controller
`timescale 1ns/1ps
`include "rstc_consts.vh"
module rstc_snoop_term_chk (
  input wire clk,
  input wire rst_b,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire bank_addr_bit0,
  input wire bank_addr_bit1,
  input wire dq_group_term_en,
  input wire [1:0] dq_group_term_sel,
  input wire cmd_addr_term_en,
  input wire addr_term_half_ref,
  input wire dual_rank
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_cmd; cmd_addr_term_en; endproperty
  a_cmd: assert property (p_cmd) else $error("cmd term off");
  property p_wait; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_wait: assert property (p_wait) else $error("more than one wait state");
  property p_excl; !(addr_term_half_ref && dual_rank); endproperty
  a_excl: assert property (p_excl) else $error("both rank modes");
  property p_dual; dual_rank |=> dual_rank; endproperty
  a_dual: assert property (p_dual) else $error("dual rank lost");
  property p_half; addr_term_half_ref |=> $stable(addr_term_half_ref); endproperty
  a_half: assert property (p_half) else $error("half ref lost");
  // off spans at least two link rises, so eight clocks is a safe floor
  property p_off; $fell(dq_group_term_en) |-> !dq_group_term_en [*8]; endproperty
  a_off: assert property (p_off) else $error("off window too short");
  property p_sel; !dq_group_term_en |-> dq_group_term_sel != `RSTC_SEL_SINGLE; endproperty
  a_sel: assert property (p_sel) else $error("off without dual load");
  property p_emr;
    $changed(dq_group_term_sel) |-> $past(bank_addr_bit0, 4) && !$past(bank_addr_bit1, 4);
  endproperty
  a_emr: assert property (p_emr) else $error("select changed without load");
  c_off: cover property ($fell(dq_group_term_en));
  c_dual: cover property ($rose(dual_rank));
  c_half: cover property ($rose(addr_term_half_ref));
endmodule // rstc_snoop_term_chk
bind rstc_snoop_term rstc_snoop_term_chk u_chk (.*);

// ---- rstc_ctrl_model.sv ----
// behavioural memory controller: command pins, strap pins and link clock
`timescale 1ns/1ps
module rstc_ctrl_model (
  input wire clk,
  output logic link_ck,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic bank_addr_bit0,
  output logic bank_addr_bit1,
  output logic [11:0] addr,
  output logic cke,
  output logic dram_reset_pin
);
  initial begin
    link_ck = 1'b0;
    {cs_n, ras_n, cas_n, we_n, bank_addr_bit1, bank_addr_bit0, addr} = {4'hF, 2'h3, 12'hFFF};
    cke = 1'b0;
    dram_reset_pin = 1'b0;
  end
  // pins settle half a link period before the rise and hold half after it
  task automatic link_cyc(input logic [3:0] c, input logic [1:0] ba, input logic [11:0] a);
    begin
      {cs_n, ras_n, cas_n, we_n, bank_addr_bit1, bank_addr_bit0, addr} <= {c, ba, a};
      repeat (4) @(posedge clk);
      link_ck <= 1'b1;
      repeat (4) @(posedge clk);
      link_ck <= 1'b0;
    end
  endtask
  task automatic strap(input logic v);
    begin
      cke <= v;
      dram_reset_pin <= 1'b0;
      repeat (4) @(posedge clk);
      dram_reset_pin <= 1'b1;
      repeat (8) @(posedge clk);
    end
  endtask
endmodule // rstc_ctrl_model

// ---- test_read_snoop_termination_ctrl.sv ----
// self-checking bench for the read snoop termination controller
`timescale 1ns/1ps
`include "rstc_consts.vh"
module test_read_snoop_termination_ctrl;
  typedef struct {int lat; int bl; logic [3:0] c; int gap; int ef; int en;} rstc_row_t;
  logic clk = 1'b0, rst_b = 1'b0, avs_read = 1'b0, avs_write = 1'b0, lk = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, q;
  wire [31:0] avs_readdata;
  wire [11:0] addr;
  wire [1:0] dq_group_term_sel;
  wire avs_waitrequest, link_ck, cs_n, ras_n, cas_n, we_n, bank_addr_bit0, bank_addr_bit1;
  wire cke, dram_reset_pin, dq_group_term_en, cmd_addr_term_en, addr_term_half_ref, dual_rank;
  int mismatches = 0, checked = 0, cyc = 0, rc = 0, noff = 0, first = 0;
  logic [1:0] sels [3] = '{`RSTC_SEL_OFF, `RSTC_SEL_SINGLE, `RSTC_SEL_DUAL};
  // read on rise 0; second read, if any, on rise gap+1
  rstc_row_t rows [5] = '{
    '{7, 4, 4'h5, 0, 7, 4},
    '{1, 4, 4'hD, 0, 1, 4},
    '{3, 8, 4'hD, 0, 3, 6},
    '{2, 2, 4'h5, 0, 2, 3},
    '{3, 4, 4'h5, 1, 3, 6}
  };
  rstc_snoop_term u_dut (.*);
  rstc_ctrl_model u_ctl (.*);
  always #12.5 clk = ~clk;
  // sampled one clock after each link rise, so it shows the previous period's result
  always @(posedge clk) begin
    if (link_ck && !lk) begin
      if (!dq_group_term_en) begin
        if (noff == 0) first = rc;
        noff++;
      end
      rc++;
    end
    lk = link_ck;
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      final_report;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      checked++;
      if (got !== exp) begin
        mismatches++;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    begin
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
        @(posedge clk);
        n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 50) chk(32'h0, 32'h1);
    end
  endtask
  task automatic snoop(input logic [3:0] c, input int gap, input int n);
    begin
      rc = 0;
      noff = 0;
      first = -1;
      u_ctl.link_cyc(c, 2'h0, 12'h0);
      repeat (gap) u_ctl.link_cyc(4'hF, 2'h3, 12'hFFF);
      if (gap > 0) u_ctl.link_cyc(c, 2'h0, 12'h0);
      repeat (n) u_ctl.link_cyc(4'hF, 2'h3, 12'hFFF);
    end
  endtask
  task automatic do_reset;
    begin
      rst_b <= 1'b0;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
    end
  endtask
  task final_report;
    begin
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial begin
    do_reset;
    bus(1'b0, `RSTC_OFS_CFG, 32'h0);
    chk(q, 32'h0001_0407);
    bus(1'b1, 4'hC, 32'hFFFF_FFFF);
    bus(1'b0, 4'hC, 32'h0);
    chk(q, 32'h0);
    $display("register test done");
    foreach (rows[i]) begin
      bus(1'b1, `RSTC_OFS_CFG, {15'h0, 1'b1, 3'h0, rows[i].bl[4:0], 4'h0, rows[i].lat[3:0]});
      snoop(rows[i].c, rows[i].gap, rows[i].lat + rows[i].bl / 2 + 3);
      chk({first[15:0], noff[15:0]}, {rows[i].ef[15:0], rows[i].en[15:0]});
    end
    bus(1'b0, `RSTC_OFS_RDCNT, 32'h0);
    chk(q, 32'h6);
    $display("snoop table done");
    foreach (sels[i]) begin
      u_ctl.link_cyc(4'h0, 2'h1, {8'h0, sels[i], 2'h0});
      u_ctl.link_cyc(4'hF, 2'h3, 12'hFFF);
      chk({30'h0, dq_group_term_sel}, {30'h0, sels[i]});
      snoop(4'h5, 0, 8);
      chk(noff, sels[i] == `RSTC_SEL_OFF ? 9 : sels[i] == `RSTC_SEL_DUAL ? 4 : 0);
    end
    bus(1'b1, `RSTC_OFS_CFG, 32'h0000_0403);
    snoop(4'hD, 0, 8);
    chk(noff, 32'h0);
    $display("select test done");
    do_reset;
    u_ctl.strap(1'b0);
    chk({29'h0, cmd_addr_term_en, addr_term_half_ref, dual_rank}, 32'h6);
    u_ctl.strap(1'b1);
    chk({29'h0, cmd_addr_term_en, addr_term_half_ref, dual_rank}, 32'h6);
    do_reset;
    u_ctl.strap(1'b1);
    chk({29'h0, cmd_addr_term_en, addr_term_half_ref, dual_rank}, 32'h5);
    $display("strap test done");
    final_report;
  end
endmodule // test_read_snoop_termination_ctrl
